// >>> design/octm_pkg.sv
// types of the clock trim and multiplier block
package octm_pkg;
    // multiplier state, gray coded along off -> enabled -> locking -> locked
    typedef enum logic [1:0] {
        OCTM_OFF     = 2'b00,
        OCTM_ENABLED = 2'b01,
        OCTM_LOCKING = 2'b11,
        OCTM_LOCKED  = 2'b10
    } octm_state_t;

    // input source selection
    typedef enum logic [1:0] {
        OCTM_SRC_INT_HALF = 2'b00,
        OCTM_SRC_EXT      = 2'b01,
        OCTM_SRC_EXT_HALF = 2'b10,
        OCTM_SRC_RSVD     = 2'b11
    } octm_src_t;
endpackage

// >>> design/octm_regs.svh
// register map, field layout and timing constants of the clock trim and multiplier block
`ifndef OCTM_REGS_SVH
`define OCTM_REGS_SVH

// register word indices (byte address is four times the index)
`define OCTM_IDX_CLOCK_MULT_CTRL       8'h97
`define OCTM_IDX_FINE         8'h9e
`define OCTM_IDX_COARSE       8'ha2

// control register fields
`define OCTM_BIT_EN           7
`define OCTM_BIT_INIT         6
`define OCTM_BIT_RDY          5
`define OCTM_DIV_HI           4
`define OCTM_DIV_LO           2
`define OCTM_SEL_HI           1
`define OCTM_SEL_LO           0

// trim field widths
`define OCTM_COARSE_W         7
`define OCTM_FINE_W           6

// default factory trims (parameter defaults only)
`define OCTM_COARSE_DEF       7'h40
`define OCTM_FINE_DEF         6'h20

// lock timing: time in ns and derived cycles at 40 MHz
`define OCTM_CLK_NS           25
`define OCTM_LOCK_NS          5000
`define OCTM_LOCK_CYC         ((`OCTM_LOCK_NS + `OCTM_CLK_NS - 1) / `OCTM_CLK_NS)

// misc values
`define OCTM_ZERO8            8'h00
`define OCTM_CNT_W            8
`define OCTM_BURST_LAST       2'h3
`endif

// >>> design/octm_top.sv
// trim registers, clock multiplier control and pulse generator behind an avalon slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "octm_regs.svh"

module octm_top #(
    parameter logic [`OCTM_COARSE_W-1:0] coarse_factory = `OCTM_COARSE_DEF,
    parameter logic [`OCTM_FINE_W-1:0]   fine_factory   = `OCTM_FINE_DEF
) (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic [9:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      int_osc_clk,
    input  wire logic                      ext_osc_clk,
    input  wire logic                      fast_tick,
    output logic      [`OCTM_COARSE_W-1:0] osc_coarse_trim,
    output logic      [`OCTM_FINE_W-1:0]   osc_fine_trim,
    output logic                           mult_enable,
    output logic      [1:0]                mult_input_select,
    output logic      [2:0]                mult_output_scale,
    output logic      [3:0]                mult_scale_num,
    output logic      [3:0]                mult_scale_den,
    output logic                           mult_locked_flag,
    output logic                           mult_clk_out
);

    // scale factor as 2/den with codes 0..2 meaning one
    function automatic logic [3:0] scale_den(input logic [2:0] code);
        logic [3:0] d;
        d = 4'h2;
        if (code > 3'h2) begin
            d = {1'b0, code};
        end
        return d;
    endfunction

    // word index decode from byte address
    function automatic logic [7:0] word_idx(input logic [9:0] a);
        return a[9:2];
    endfunction

    // selected multiplier input as a level; halved sources toggle per rising edge
    logic [1:0] int_sync;
    logic [1:0] ext_sync;
    logic       int_prev;
    logic       ext_prev;
    logic       int_half;
    logic       ext_half;
    logic [1:0] next_int_sync;
    logic [1:0] next_ext_sync;
    logic       next_int_prev;
    logic       next_ext_prev;
    logic       next_int_half;
    logic       next_ext_half;

    // register and state storage
    logic                      ack;
    logic                      next_ack;
    logic                      next_waitrequest;
    logic [31:0]               next_readdata;
    logic [`OCTM_COARSE_W-1:0] next_coarse;
    logic [`OCTM_FINE_W-1:0]   next_fine;
    logic                      next_en;
    logic [1:0]                next_sel;
    logic [2:0]                next_div;
    logic                      init_bit;
    logic                      next_init_bit;
    octm_pkg::octm_state_t     state;
    octm_pkg::octm_state_t     next_state;
    logic [`OCTM_CNT_W-1:0]    lock_cnt;
    logic [`OCTM_CNT_W-1:0]    next_lock_cnt;
    logic                      next_locked;
    logic                      ref_now;
    logic                      ref_last;
    logic                      next_ref_last;
    logic                      burst_on;
    logic                      next_burst_on;
    logic [1:0]                burst_cnt;
    logic [1:0]                next_burst_cnt;
    logic                      next_clk_out;
    logic [3:0]                next_num;
    logic [3:0]                next_den;
    logic                      wr_hit;
    logic                      rd_hit;
    logic [7:0]                wbyte;
    logic [7:0]                ctrl_rd;

    // synchronisers and halving dividers on the oscillator inputs
    always_comb begin
        next_int_sync = {int_sync[0], int_osc_clk};
        next_ext_sync = {ext_sync[0], ext_osc_clk};
        next_int_prev = int_sync[1];
        next_ext_prev = ext_sync[1];
        next_int_half = int_half ^ (int_sync[1] & ~int_prev);
        next_ext_half = ext_half ^ (ext_sync[1] & ~ext_prev);
    end

    // synchroniser and divider registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            int_sync <= 2'h0;
            ext_sync <= 2'h0;
            int_prev <= 1'b0;
            ext_prev <= 1'b0;
            int_half <= 1'b0;
            ext_half <= 1'b0;
        end else begin
            int_sync <= next_int_sync;
            ext_sync <= next_ext_sync;
            int_prev <= next_int_prev;
            ext_prev <= next_ext_prev;
            int_half <= next_int_half;
            ext_half <= next_ext_half;
        end
    end

    // input source choice
    always_comb begin
        case (octm_pkg::octm_src_t'(mult_input_select))
            octm_pkg::OCTM_SRC_INT_HALF: ref_now = int_half;
            octm_pkg::OCTM_SRC_EXT:      ref_now = ext_prev;
            octm_pkg::OCTM_SRC_EXT_HALF: ref_now = ext_half;
            default:                     ref_now = 1'b0;
        endcase
    end

    // bus decode: read taken on first edge, write lands on the answer edge
    assign wr_hit = avs_write & ack;
    assign rd_hit = avs_read & ~ack;
    assign wbyte  = avs_writedata[7:0];

    // control readback laid out by field position
    always_comb begin
        ctrl_rd                            = `OCTM_ZERO8;
        ctrl_rd[`OCTM_BIT_EN]              = mult_enable;
        ctrl_rd[`OCTM_BIT_INIT]            = init_bit;
        ctrl_rd[`OCTM_BIT_RDY]             = mult_locked_flag;
        ctrl_rd[`OCTM_DIV_HI:`OCTM_DIV_LO] = mult_output_scale;
        ctrl_rd[`OCTM_SEL_HI:`OCTM_SEL_LO] = mult_input_select;
    end

    // register writes, readback and multiplier control state
    always_comb begin
        next_ack      = (avs_read | avs_write) & ~ack;
        next_readdata = avs_readdata;
        next_coarse   = osc_coarse_trim;
        next_fine     = osc_fine_trim;
        next_en       = mult_enable;
        next_sel      = mult_input_select;
        next_div      = mult_output_scale;
        next_init_bit = init_bit;
        next_state    = state;
        next_lock_cnt = lock_cnt;
        if (rd_hit) begin
            case (word_idx(avs_address))
                `OCTM_IDX_CLOCK_MULT_CTRL: next_readdata = {24'h000000, ctrl_rd};
                `OCTM_IDX_FINE:   next_readdata = {26'h0000000, osc_fine_trim};
                `OCTM_IDX_COARSE: next_readdata = {25'h0000000, osc_coarse_trim};
                default:          next_readdata = 32'h00000000;
            endcase
        end
        if (wr_hit && avs_byteenable[0]) begin
            case (word_idx(avs_address))
                `OCTM_IDX_CLOCK_MULT_CTRL: begin
                    next_en  = wbyte[`OCTM_BIT_EN];
                    next_sel = wbyte[`OCTM_SEL_HI:`OCTM_SEL_LO];
                    next_div = wbyte[`OCTM_DIV_HI:`OCTM_DIV_LO];
                    // clearing enable drops init and lock at once
                    if (!wbyte[`OCTM_BIT_EN]) begin
                        next_init_bit = 1'b0;
                        next_state    = octm_pkg::OCTM_OFF;
                    end else if (!mult_enable) begin
                        next_init_bit = 1'b0;
                        next_state    = octm_pkg::OCTM_ENABLED;
                    end else if (wbyte[`OCTM_BIT_INIT]) begin
                        next_init_bit = 1'b1;
                        next_state    = octm_pkg::OCTM_LOCKING;
                        next_lock_cnt = `OCTM_CNT_W'(`OCTM_LOCK_CYC);
                    end
                end
                `OCTM_IDX_FINE:   next_fine   = wbyte[`OCTM_FINE_W-1:0];
                `OCTM_IDX_COARSE: next_coarse = wbyte[`OCTM_COARSE_W-1:0];
                default: ;
            endcase
        end else begin
            // lock countdown, paused while a write lands
            case (state)
                octm_pkg::OCTM_LOCKING: begin
                    if (lock_cnt == `OCTM_CNT_W'(0)) begin
                        next_state = octm_pkg::OCTM_LOCKED;
                    end else begin
                        next_lock_cnt = lock_cnt - `OCTM_CNT_W'(1);
                    end
                end
                default: ;
            endcase
        end
        next_locked = (next_state == octm_pkg::OCTM_LOCKED);
        next_den    = scale_den(next_div);
        next_num    = (next_div > 3'h2) ? 4'h2 : 4'h2; // numerator is always two over den
        next_waitrequest = ~next_ack; // low for one cycle per access
    end

    // bus, register and lock state registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ack               <= 1'b0;
            avs_readdata      <= 32'h00000000;
            osc_coarse_trim   <= coarse_factory;
            osc_fine_trim     <= fine_factory;
            mult_enable       <= 1'b0;
            mult_input_select <= 2'h0;
            mult_output_scale <= 3'h0;
            init_bit          <= 1'b0;
            state             <= octm_pkg::OCTM_OFF;
            lock_cnt          <= `OCTM_CNT_W'(0);
            mult_locked_flag  <= 1'b0;
            mult_scale_num    <= 4'h2;
            mult_scale_den    <= 4'h2;
            avs_waitrequest   <= 1'b1;
        end else begin
            ack               <= next_ack;
            avs_readdata      <= next_readdata;
            osc_coarse_trim   <= next_coarse;
            osc_fine_trim     <= next_fine;
            mult_enable       <= next_en;
            mult_input_select <= next_sel;
            mult_output_scale <= next_div;
            init_bit          <= next_init_bit;
            state             <= next_state;
            lock_cnt          <= next_lock_cnt;
            mult_locked_flag  <= next_locked;
            mult_scale_num    <= next_num;
            mult_scale_den    <= next_den;
            avs_waitrequest   <= next_waitrequest;
        end
    end

    // four fast pulses per reference rising edge, then hold
    always_comb begin
        next_ref_last  = ref_now;
        next_burst_on  = burst_on;
        next_burst_cnt = burst_cnt;
        next_clk_out   = 1'b0;
        if (!mult_locked_flag) begin
            next_burst_on  = 1'b0;
            next_burst_cnt = 2'h0;
        end else if (ref_now && !ref_last) begin
            next_burst_on  = 1'b1;
            next_burst_cnt = 2'h0;
        end else if (burst_on && fast_tick) begin
            next_clk_out = ~mult_clk_out;
            if (mult_clk_out) begin
                if (burst_cnt == `OCTM_BURST_LAST) begin
                    next_burst_on = 1'b0;
                end
                next_burst_cnt = burst_cnt + 2'h1;
            end
        end else begin
            next_clk_out = mult_clk_out & burst_on;
        end
    end

    // burst generator registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ref_last     <= 1'b0;
            burst_on     <= 1'b0;
            burst_cnt    <= 2'h0;
            mult_clk_out <= 1'b0;
        end else begin
            ref_last     <= next_ref_last;
            burst_on     <= next_burst_on;
            burst_cnt    <= next_burst_cnt;
            mult_clk_out <= next_clk_out;
        end
    end

endmodule

// >>> dv/octm_top_monitor.sv
// port assertions for the clock trim and multiplier block
`timescale 1ns/1ps
`include "octm_regs.svh"
module octm_top_monitor (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [6:0]  osc_coarse_trim,
    input wire logic [5:0]  osc_fine_trim,
    input wire logic        mult_enable,
    input wire logic [1:0]  mult_input_select,
    input wire logic [2:0]  mult_output_scale,
    input wire logic [3:0]  mult_scale_num,
    input wire logic [3:0]  mult_scale_den,
    input wire logic        mult_locked_flag,
    input wire logic        mult_clk_out
);
    logic [7:0] idx;
    logic       done;
    logic       wr_done;
    // register index and completing accesses
    assign idx     = avs_address[9:2];
    assign done    = !avs_waitrequest;
    assign wr_done = done && avs_write && avs_byteenable[0];
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    a_answer_next: assert property ((avs_read || avs_write) && !done |=> done ##1 !done)
        else $error("bus answer not one cycle");
    a_coarse_read: assert property (done && avs_read && idx == `OCTM_IDX_COARSE
        |-> avs_readdata[7:0] == {1'b0, osc_coarse_trim}) else $error("coarse readback wrong");
    a_fine_read: assert property (done && avs_read && idx == `OCTM_IDX_FINE
        |-> avs_readdata[7:0] == {2'b00, osc_fine_trim}) else $error("fine readback wrong");
    a_ctrl_read: assert property (done && avs_read && idx == `OCTM_IDX_CLOCK_MULT_CTRL |-> (avs_readdata[7:0] & 8'hbf) ==
        $past({mult_enable, 1'b0, mult_locked_flag, mult_output_scale, mult_input_select}))
        else $error("control readback wrong");
    a_trim_hold: assert property (!$stable({osc_coarse_trim, osc_fine_trim}) |->
        $past(wr_done && (idx == `OCTM_IDX_COARSE || idx == `OCTM_IDX_FINE))) else $error("trim moved alone");
    a_off_unready: assert property (!mult_enable ##1 !mult_enable |-> !mult_locked_flag)
        else $error("ready while disabled");
    a_lock_early: assert property ($rose(mult_locked_flag) |-> $past(mult_enable, 195))
        else $error("lock too soon");
    a_lock_bound: assert property (wr_done && idx == `OCTM_IDX_CLOCK_MULT_CTRL && avs_writedata[7:6] == 2'b11
        && mult_enable && !mult_locked_flag |-> ##[1:260] (mult_locked_flag || !mult_enable))
        else $error("lock never came");
    a_scale_code: assert property ($stable(mult_output_scale) ##1 $stable(mult_output_scale) |->
        mult_scale_num == 4'h2 && mult_scale_den == (mult_output_scale < 3'h3 ? 4'h2 : {1'b0, mult_output_scale}))
        else $error("scale ratio wrong");
    a_out_quiet: assert property (!mult_locked_flag [*2] |-> !mult_clk_out)
        else $error("pulses while unlocked");
endmodule
bind octm_top octm_top_monitor octm_top_monitor_inst (
    .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest,
    .osc_coarse_trim, .osc_fine_trim, .mult_enable, .mult_input_select, .mult_output_scale,
    .mult_scale_num, .mult_scale_den, .mult_locked_flag, .mult_clk_out
);

// >>> dv/tb_octm_top.sv
// self-checking bench for the clock trim and multiplier block
`timescale 1ns/1ps
`include "octm_regs.svh"
module tb_octm_top;
    localparam logic [6:0] coarse_fac = 7'h5a;
    localparam logic [5:0] fine_fac   = 6'h13;
    localparam logic [7:0] im         = `OCTM_IDX_CLOCK_MULT_CTRL;
    localparam logic [7:0] ic         = `OCTM_IDX_COARSE;
    localparam logic [7:0] ifn        = `OCTM_IDX_FINE;
    logic        mclk            = 1'b0;
    logic        nrst            = 1'b0;
    logic [9:0]  avs_address     = 10'h000;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        int_osc_clk     = 1'b0;
    logic        ext_osc_clk     = 1'b0;
    logic        fast_tick       = 1'b0;
    logic [6:0]  osc_coarse_trim;
    logic [5:0]  osc_fine_trim;
    logic        mult_enable;
    logic [1:0]  mult_input_select;
    logic [2:0]  mult_output_scale;
    logic [3:0]  mult_scale_num;
    logic [3:0]  mult_scale_den;
    logic        mult_locked_flag;
    logic        mult_clk_out;
    logic [4:0]  ref_cnt         = 5'h00;
    int          error_cnt       = 0;
    int          total_checks    = 0;
    octm_top #(.coarse_factory(coarse_fac), .fine_factory(fine_fac)) octm_top_inst (
        .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .int_osc_clk, .ext_osc_clk, .fast_tick, .osc_coarse_trim,
        .osc_fine_trim, .mult_enable, .mult_input_select, .mult_output_scale, .mult_scale_num,
        .mult_scale_den, .mult_locked_flag, .mult_clk_out
    );
    // 40 mhz system clock
    always #12.5 mclk = ~mclk;
    // slow oscillator levels and burst pacing tick
    always @(posedge mclk) begin
        ref_cnt <= ref_cnt + 5'h01;
        int_osc_clk <= ref_cnt[4];
        ext_osc_clk <= ref_cnt[2];
        fast_tick <= ~fast_tick;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        total_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic be0,
                        output logic [7:0] rd);
        int n;
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h7, be0};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) begin
            $display("CHECK FAILED waitrequest expected 0 seen %b", avs_waitrequest);
            error_cnt++;
            final_report();
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic be0);
        logic [7:0] unused;
        xfer(1'b1, idx, d, be0, unused);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
        logic [7:0] got;
        xfer(1'b0, idx, 8'h00, 1'b1, got);
        chk(nm, ex, got);
    endtask
    // main sequence
    initial begin
        logic [7:0] v;
        logic       prev;
        int         n;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(ic, {1'b0, coarse_fac}, "coarse reset");
        rd_chk(ifn, {2'b00, fine_fac}, "fine reset");
        rd_chk(im, 8'h00, "ctrl reset");
        wr(ic, 8'hff, 1'b1);
        rd_chk(ic, 8'h7f, "coarse ones");
        chk("coarse port", 8'h7f, {1'b0, osc_coarse_trim});
        wr(ic, 8'h80, 1'b1);
        rd_chk(ic, 8'h00, "coarse zeros");
        wr(ifn, 8'hff, 1'b1);
        wr(ifn, 8'h15, 1'b0);
        rd_chk(ifn, 8'h3f, "fine ones");
        wr(8'h10, 8'hff, 1'b1);
        rd_chk(8'h10, 8'h00, "unmapped");
        $display("test trims done");
        wr(im, 8'h00, 1'b1);
        for (int c = 0; c < 32; c++) begin
            wr(im, c[7:0], 1'b1);
            rd_chk(im, c[7:0], "ctrl fields");
            chk("scale den", (c[4:2] < 3) ? 8'h02 : {5'h00, c[4:2]}, {4'h0, mult_scale_den});
            chk("scale num", 8'h02, {4'h0, mult_scale_num});
            chk("select", {6'h00, c[1:0]}, {6'h00, mult_input_select});
        end
        $display("test fields done");
        wr(im, 8'h00, 1'b1);
        wr(im, 8'h80, 1'b1);
        rd_chk(im, 8'h80, "enabled no init");
        repeat (201) @(posedge mclk);
        wr(im, 8'hc0, 1'b1);
        rd_chk(im, 8'hc0, "init not ready");
        n = 0;
        do begin
            xfer(1'b0, im, 8'h00, 1'b1, v);
            n++;
        end while (v[5] !== 1'b1 && n < 150);
        chk("ready flag", 8'he0, v);
        prev = mult_clk_out;
        n = 0;
        repeat (640) begin
            @(posedge mclk);
            if (mult_clk_out === 1'b1 && prev === 1'b0) n++;
            prev = mult_clk_out;
        end
        chk("burst rate", 8'h01, {7'h00, n >= 36 && n <= 44});
        $display("test lock done");
        wr(im, 8'h00, 1'b1);
        rd_chk(im, 8'h00, "ready after off");
        wr(im, 8'h40, 1'b1);
        repeat (210) @(posedge mclk);
        rd_chk(im, 8'h00, "init while off");
        chk("lock port", 8'h00, {7'h00, mult_locked_flag});
        $display("test disable done");
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(ic, {1'b0, coarse_fac}, "coarse rereset");
        rd_chk(ifn, {2'b00, fine_fac}, "fine rereset");
        rd_chk(im, 8'h00, "ctrl rereset");
        $display("test reset done");
        final_report();
    end
endmodule
